/* hdl/scpr_serial_port_regs.v */
/*
  Two-wire serial slave and the low-address configuration registers of a
  clock generator: soft reset, revision, variant code, readback select,
  user identifier and the first loop control register.
  Assumes scl and sda arrive from pins; sda is open drain and is driven
  low only while sda_oe is high. io_update copies buffer to active.
*/
`default_nettype none
`include "scpr_defines.vh"

module scpr_serial_port_regs #(
  parameter [6:0] DEV_ADDR     = 7'h58,
  // Arbitrary revision and variant values.
  parameter [7:0] SILICON_REV  = 8'h01,
  parameter [7:0] VARIANT_CODE = 8'h5A
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire       io_update,
  output wire       phase_frequency_detector_neg,
  output wire [2:0] pump_current_code,
  output wire       soft_reset_pending
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DEV  = 3'd1;
  localparam [2:0] ST_AHI  = 3'd2;
  localparam [2:0] ST_ALO  = 3'd3;
  localparam [2:0] ST_WR   = 3'd4;
  localparam [2:0] ST_RD   = 3'd5;
  localparam [2:0] ST_RACK = 3'd6;

  wire        scl_s;
  wire        sda_s;
  reg         scl_d_ff;
  reg         sda_d_ff;
  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;

  reg  [2:0]  st_ff;
  reg  [3:0]  bit_ff;
  reg  [7:0]  sh_ff;
  reg  [15:0] addr_ff;
  reg         oe_ff;
  reg         rw_ff;
  reg         nack_ff;
  wire        wr_en;

  reg         soft_rst_ff;
  reg         rdbk_sel_ff;
  reg  [7:0]  buf_uid_lo_ff;
  reg  [7:0]  buf_uid_hi_ff;
  reg  [7:0]  buf_loop_ff;
  reg  [7:0]  act_uid_lo_ff;
  reg  [7:0]  act_uid_hi_ff;
  reg  [7:0]  act_loop_ff;
  reg  [7:0]  rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning and bus events.

  scpr_pin_filter #(
    .STABLE_CYCLES (`SCPR_SPIKE_CYCLES),
    .RESET_LEVEL   (1'b1)
  ) u_scl_filter (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (scl_in),
    .level_out (scl_s)
  );

  scpr_pin_filter #(
    .STABLE_CYCLES (`SCPR_SPIKE_CYCLES),
    .RESET_LEVEL   (1'b1)
  ) u_sda_filter (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (sda_in),
    .level_out (sda_s)
  );

  always @(posedge clk) begin
    if (sys_rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Readback multiplexer.

  always @* begin
    rd_data = 8'h00;
    case (addr_ff)
      `SCPR_OFS_CONFIG: begin
        rd_data[`SCPR_CFG_SOFT_RST] = soft_rst_ff; // [RULE_10]
        rd_data[`SCPR_CFG_MIRROR]   = soft_rst_ff; // [RULE_02]
      end
      `SCPR_OFS_REVISION: rd_data = SILICON_REV;  // [RULE_03]
      `SCPR_OFS_VARIANT:  rd_data = VARIANT_CODE; // [RULE_04]
      `SCPR_OFS_RDBK_SEL: rd_data[`SCPR_RDBK_SEL_BIT] = rdbk_sel_ff;
      `SCPR_OFS_UID_LO: begin
        rd_data = rdbk_sel_ff ? act_uid_lo_ff : buf_uid_lo_ff; // [RULE_05] [RULE_06]
      end
      `SCPR_OFS_UID_HI: begin
        rd_data = rdbk_sel_ff ? act_uid_hi_ff : buf_uid_hi_ff; // [RULE_05] [RULE_06]
      end
      `SCPR_OFS_LOOP_CTRL: begin
        rd_data = rdbk_sel_ff ? act_loop_ff : buf_loop_ff; // [RULE_05]
      end
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial protocol engine: device address, two address bytes, then data.
  // The address advances after every data byte in both directions.

  task load_read;
    begin
      sh_ff   <= rd_data;
      oe_ff   <= ~rd_data[7];
      bit_ff  <= 4'd1;
      addr_ff <= addr_ff + 16'h0001;
      st_ff   <= ST_RD;
    end
  endtask

  always @(posedge clk) begin
    if (sys_rst) begin
      st_ff   <= ST_IDLE;
      bit_ff  <= 4'd0;
      sh_ff   <= 8'h00;
      addr_ff <= 16'h0000;
      oe_ff   <= 1'b0;
      rw_ff   <= 1'b0;
      nack_ff <= 1'b0;
    end else if (bus_start) begin
      st_ff  <= ST_DEV;
      bit_ff <= 4'd0;
      oe_ff  <= 1'b0;
    end else if (bus_stop) begin
      st_ff <= ST_IDLE;
      oe_ff <= 1'b0;
    end else begin
      case (st_ff)
        ST_DEV, ST_AHI, ST_ALO, ST_WR: begin
          if (scl_rise && bit_ff < 4'd8) begin
            sh_ff  <= {sh_ff[6:0], sda_s};
            bit_ff <= bit_ff + 4'd1;
          end else if (scl_fall && bit_ff == 4'd8) begin
            bit_ff <= 4'd9;
            oe_ff  <= 1'b1;
            case (st_ff)
              ST_DEV: begin
                rw_ff <= sh_ff[0];
                if (sh_ff[7:1] != DEV_ADDR) begin
                  st_ff <= ST_IDLE;
                  oe_ff <= 1'b0;
                end
              end
              ST_AHI:  addr_ff[15:8] <= sh_ff;
              ST_ALO:  addr_ff[7:0]  <= sh_ff;
              default: addr_ff <= addr_ff + 16'h0001;
            endcase
          end else if (scl_fall && bit_ff == 4'd9) begin
            bit_ff <= 4'd0;
            oe_ff  <= 1'b0;
            case (st_ff)
              ST_DEV: begin
                if (rw_ff) begin
                  load_read;
                end else begin
                  st_ff <= ST_AHI;
                end
              end
              ST_AHI:  st_ff <= ST_ALO;
              default: st_ff <= ST_WR;
            endcase
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_ff == 4'd8) begin
              oe_ff <= 1'b0;
              st_ff <= ST_RACK;
            end else begin
              sh_ff  <= {sh_ff[6:0], 1'b0};
              oe_ff  <= ~sh_ff[6];
              bit_ff <= bit_ff + 4'd1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nack_ff <= sda_s;
          end else if (scl_fall) begin
            if (nack_ff) begin
              st_ff <= ST_IDLE;
            end else begin
              load_read;
            end
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  assign wr_en = scl_fall & (st_ff == ST_WR) & (bit_ff == 4'd8) & ~bus_start & ~bus_stop;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank. User identifier and loop control writes land in the buffer copies; io_update moves them
  // to the active copies, of which only the loop copy steers the loop.

  always @(posedge clk) begin
    if (sys_rst || (soft_rst_ff && scl_rise)) begin // [RULE_01]
      soft_rst_ff   <= 1'b0;
      rdbk_sel_ff   <= `SCPR_RST_RDBK_SEL;
      buf_uid_lo_ff <= `SCPR_RST_UID_BYTE;
      buf_uid_hi_ff <= `SCPR_RST_UID_BYTE;
      buf_loop_ff   <= `SCPR_RST_LOOP_CTRL;
      act_uid_lo_ff <= `SCPR_RST_UID_BYTE;
      act_uid_hi_ff <= `SCPR_RST_UID_BYTE;
      act_loop_ff   <= `SCPR_RST_LOOP_CTRL;
    end else begin
      if (wr_en) begin
        case (addr_ff)
          `SCPR_OFS_CONFIG: begin
            soft_rst_ff <= soft_rst_ff | sh_ff[`SCPR_CFG_SOFT_RST]; // [RULE_01] [RULE_10]
          end
          `SCPR_OFS_RDBK_SEL: rdbk_sel_ff <= sh_ff[`SCPR_RDBK_SEL_BIT]; // [RULE_05]
          `SCPR_OFS_UID_LO:   buf_uid_lo_ff <= sh_ff; // [RULE_06]
          `SCPR_OFS_UID_HI:   buf_uid_hi_ff <= sh_ff; // [RULE_06]
          `SCPR_OFS_LOOP_CTRL: buf_loop_ff <= sh_ff;
          default: ; // [RULE_03] [RULE_04]
        endcase
      end
      if (io_update) begin
        act_uid_lo_ff <= buf_uid_lo_ff;
        act_uid_hi_ff <= buf_uid_hi_ff;
        act_loop_ff   <= buf_loop_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. The user identifier drives nothing but readback.

  assign sda_out            = 1'b0;
  assign sda_oe             = oe_ff;
  assign soft_reset_pending = soft_rst_ff;
  assign phase_frequency_detector_neg = act_loop_ff[`SCPR_LOOP_POL_BIT]; // [RULE_08] [RULE_07]
  assign pump_current_code  = act_loop_ff[`SCPR_LOOP_CP_MSB:`SCPR_LOOP_CP_LSB]; // [RULE_09]

endmodule // scpr_serial_port_regs

`default_nettype wire

/* inc/scpr_defines.vh */
/*
  Constants for the serial port configuration register bank: register
  offsets, field positions, reset values and timing of the pin filter.
  Assumes it is included by bare name from the design files under hdl/.
*/
// Operation
// [RULE_01] Config bit 5 soft-resets registers, self-clears
// [RULE_02] Host mirrors config high nibble into low
// [RULE_03] Offset 0x002 is read-only silicon revision
// [RULE_04] Offset 0x003 is read-only variant code
// [RULE_05] Offset 0x004 bit 0 selects readback bank
// [RULE_06] Offsets 0x005/0x006 hold 16-bit user identifier
// [RULE_07] User identifier affects no device function
// [RULE_08] Loop control bit 7 sets detector polarity
// [RULE_09] Loop control bits 6:4 are pump current code
// [RULE_10] Config bits 7, 6, 4 read zero
`ifndef SCPR_DEFINES_VH
`define SCPR_DEFINES_VH

`define SCPR_OFS_CONFIG     16'h0000
`define SCPR_OFS_REVISION   16'h0002
`define SCPR_OFS_VARIANT    16'h0003
`define SCPR_OFS_RDBK_SEL   16'h0004
`define SCPR_OFS_UID_LO     16'h0005
`define SCPR_OFS_UID_HI     16'h0006
`define SCPR_OFS_LOOP_CTRL  16'h0010

`define SCPR_CFG_SOFT_RST   5
`define SCPR_CFG_MIRROR     2
`define SCPR_RDBK_SEL_BIT   0
`define SCPR_LOOP_POL_BIT   7
`define SCPR_LOOP_CP_MSB    6
`define SCPR_LOOP_CP_LSB    4

`define SCPR_RST_RDBK_SEL   1'h0
`define SCPR_RST_UID_BYTE   8'h00
`define SCPR_RST_LOOP_CTRL  8'h7D

`define SCPR_CLK_PERIOD_NS  4
`define SCPR_SPIKE_NS       50
`define SCPR_SPIKE_CYCLES   ((`SCPR_SPIKE_NS + `SCPR_CLK_PERIOD_NS - 1) / `SCPR_CLK_PERIOD_NS)

`endif

/* hdl/scpr_pin_filter.v */
/*
  Two-flop synchroniser followed by a spike filter for one serial pin.
  Assumes the pin is asynchronous to clk; the output changes only after
  the synchronised level has been stable for STABLE_CYCLES cycles.
*/
`default_nettype none

module scpr_pin_filter #(
  parameter integer STABLE_CYCLES = 13,
  parameter         RESET_LEVEL   = 1'b1
) (
  input  wire clk,
  input  wire sys_rst,
  input  wire pin_in,
  output wire level_out
);

  reg       meta_ff;
  reg       sync_ff;
  reg       level_ff;
  reg [7:0] cnt_ff;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_ff  <= RESET_LEVEL;
      sync_ff  <= RESET_LEVEL;
      level_ff <= RESET_LEVEL;
      cnt_ff   <= 8'h00;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      if (sync_ff == level_ff) begin
        cnt_ff <= 8'h00;
      end else if (cnt_ff >= STABLE_CYCLES[7:0] - 8'h01) begin
        level_ff <= sync_ff;
        cnt_ff   <= 8'h00;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  assign level_out = level_ff;

endmodule // scpr_pin_filter

`default_nettype wire

/* sim/scpr_i2c_host.sv */
/* Two-wire host model that drives scl and pulls sda low.
   Assumes the bench resolves the open-drain sda line with a pull-up. */
`default_nettype none
////////////////////////////////////////////////////////////////////////
module scpr_i2c_host #(parameter logic [6:0] DEV = 7'h58) (
  input  wire logic clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // A step of 21 cycles (scl high for one step, low for two) keeps every level long enough for the pin filter.
  task automatic hw;
    repeat (21) @(posedge clk);
    #1;
  endtask
  task automatic start;
    sda_low = 1'h0;
    hw;
    scl = 1'h1;
    hw;
    sda_low = 1'h1;
    hw;
    scl = 1'h0;
    hw;
  endtask
  task automatic stop;
    sda_low = 1'h1;
    hw;
    scl = 1'h1;
    hw;
    sda_low = 1'h0;
    hw;
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_low = !b;
    hw;
    scl = 1'h1;
    hw;
    r = sda_line;
    scl = 1'h0;
    hw;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, r);
    ack = !r;
  endtask
  task automatic addr_phase(input logic [15:0] a);
    logic [7:0] q;
    logic k;
    start;
    xbyte({DEV, 1'h0}, 1'h1, q, k);
    xbyte(a[15:8], 1'h1, q, k);
    xbyte(a[7:0], 1'h1, q, k);
  endtask
  task automatic write_reg(input logic [15:0] a, input logic [7:0] d, output logic ack);
    logic [7:0] q;
    addr_phase(a);
    xbyte(d, 1'h1, q, ack);
    stop;
  endtask
  task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic k;
    addr_phase(a);
    start;
    xbyte({DEV, 1'h1}, 1'h1, q, k);
    xbyte(8'hFF, 1'h1, d, k);
    stop;
  endtask
endmodule // scpr_i2c_host
`default_nettype wire

/* sim/scpr_serial_port_regs_asserts.sv */
/* Checker on the ports of the register bank.
   Assumes the bench host keeps scl low for 42 cycles after each fall. */
`default_nettype none
////////////////////////////////////////////////////////////////////////
module scpr_serial_port_regs_asserts (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       io_update,
  input wire logic       phase_frequency_detector_neg,
  input wire logic [2:0] pump_current_code,
  input wire logic       soft_reset_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reset_defaults_a: assert property ($fell(sys_rst) |-> !phase_frequency_detector_neg &&
    pump_current_code == 3'h7 && !soft_reset_pending) else $error("bad reset outputs");
  polarity_update_a: assert property ($changed(phase_frequency_detector_neg) |->
    $past(io_update) || $past(soft_reset_pending) || $past(soft_reset_pending, 2))
    else $error("polarity moved without update");
  pump_update_a: assert property ($changed(pump_current_code) |->
    $past(io_update) || $past(soft_reset_pending) || $past(soft_reset_pending, 2))
    else $error("pump code moved without update");
  pending_clear_a: assert property ($rose(soft_reset_pending) |-> ##[1:120]
    !soft_reset_pending) else $error("soft reset never cleared");
  softrst_defaults_a: assert property ($fell(soft_reset_pending) |-> ##[0:2]
    (pump_current_code == 3'h7 && !phase_frequency_detector_neg)) else $error("no defaults");
  pending_hold_a: assert property ($rose(soft_reset_pending) |=> soft_reset_pending [*8])
    else $error("soft reset pending too short");
  pending_scl_low_a: assert property ($rose(soft_reset_pending) |-> !scl_in)
    else $error("soft reset raised with scl high");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in || $past(soft_reset_pending))
    else $error("sda drive changed with scl high");
  cover property ($rose(soft_reset_pending));
  cover property ($rose(phase_frequency_detector_neg));
  cover property ($rose(sda_oe));
endmodule // scpr_serial_port_regs_asserts
bind scpr_serial_port_regs scpr_serial_port_regs_asserts scpr_serial_port_regs_asserts_i (
  .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .io_update(io_update),
  .phase_frequency_detector_neg(phase_frequency_detector_neg),
  .pump_current_code(pump_current_code), .soft_reset_pending(soft_reset_pending));
`default_nettype wire

/* sim/scpr_serial_port_regs_test.sv */
/* Bench: a two-wire host writes and reads the register bank.
   Assumes the host model file and the checker are compiled first. */
`default_nettype none
////////////////////////////////////////////////////////////////////////
module scpr_serial_port_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'h01;  // Arbitrary value.
  localparam logic [7:0] VAR = 8'h5A;  // Arbitrary value.
  logic       clk = 1'h0;
  logic       sys_rst = 1'h1;
  logic       io_update = 1'h0;
  logic       scl, sda_low, sda_out, sda_oe, pol, pend, ack;
  logic [2:0] pump;
  logic [7:0] q;
  int         errors = 0;
  int         checks = 0;
  wire logic  sda_line = !(sda_low || (sda_oe && !sda_out));
  always #2 clk = !clk;
  scpr_serial_port_regs #(.SILICON_REV(REV), .VARIANT_CODE(VAR)) scpr_serial_port_regs_i (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .io_update(io_update), .phase_frequency_detector_neg(pol),
    .pump_current_code(pump), .soft_reset_pending(pend));
  scpr_i2c_host host_i (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    host_i.read_reg(a, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host_i.write_reg(a, d, ack);
    chk({7'h00, ack}, 8'h01);
  endtask
  task automatic upd;
    io_update = 1'h1;
    @(posedge clk);
    #1;
    io_update = 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    results;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    repeat (40) @(posedge clk);
    chk({4'h0, pol, pump}, 8'h07);
    rd(16'h0004, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(16'h0002 + i, 8'hFF);
      rd(16'h0002 + i, i ? VAR : REV);
    end
    $display("test identity done");
    rd(16'h0006, 8'h00);
    wr(16'h0005, 8'h3C);
    wr(16'h0006, 8'hC3);
    rd(16'h0005, 8'h3C);
    rd(16'h0006, 8'hC3);
    upd;
    chk({4'h0, pol, pump}, 8'h07);
    $display("test user identifier done");
    wr(16'h0010, 8'hA0);
    chk({4'h0, pol, pump}, 8'h07);
    rd(16'h0010, 8'hA0);
    wr(16'h0004, 8'h01);
    rd(16'h0010, 8'h7D);
    upd;
    chk({4'h0, pol, pump}, 8'h0A);
    rd(16'h0010, 8'hA0);
    for (int c = 0; c < 3; c++) begin
      wr(16'h0010, {1'h0, c[2:0], 4'hD});
      upd;
      chk({4'h0, pol, pump}, {5'h00, c[2:0]});
    end
    $display("test loop control done");
    wr(16'h0000, 8'hDB);
    rd(16'h0000, 8'h00);
    wr(16'h0000, 8'h24);
    chk({4'h0, pol, pump}, 8'h07);
    chk({7'h00, pend}, 8'h00);
    rd(16'h0000, 8'h00);
    rd(16'h0004, 8'h00);
    rd(16'h0010, 8'h7D);
    rd(16'h0005, 8'h00);
    $display("test soft reset done");
    results;
  end
endmodule // scpr_serial_port_regs_test
`default_nettype wire
